// file: src/fmr_io_map.sv
// I/O function mapping register bank of the soft starter
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module fmr_io_map
  import fmr_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // Parameter port
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Converter samples (same clock)
  input  wire logic [10:0] adc_code,
  input  wire logic [10:0] therm_code,
  // Digital input pins: first, second, third
  input  wire logic [2:0]  din_pin,
  // Starter status levels
  input  wire logic        stat_ready,
  input  wire logic        stat_enabled,
  input  wire logic        stat_error,
  input  wire logic        stat_running,
  input  wire logic        stat_start_complete,
  input  wire logic        stat_current_limit,
  input  wire logic        stat_energy_saving_active,
  // Mapped functions
  output logic             fn_start_stop,
  output logic             fn_ramp_freeze,
  output logic             fn_fault_reset,
  output logic             fn_energy_saving_mode,
  output logic             fn_external_trip_input,
  // Analogue-driven levels
  output logic      [15:0] ai_level,
  output logic      [2:0]  ai_target,
  // Thermal protection
  output logic             therm_trip,
  // Relays: NC, first NO, second NO
  output logic      [2:0]  relay_out,
  // Interrupt
  output logic             irq
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [15:0]      ai_sel;
    logic [15:0]      ai_scale;
    logic [10:0]      ai_read;
    logic [10:0]      therm_read;
    logic [2:0][15:0] din_sel;
    logic [2:0][15:0] rly_sel;
    logic [1:0]       ctrl;
    logic [2:0]       irq_stat;
    logic [2:0]       irq_mask;
    logic [15:0]      rdata;
    logic [2:0]       din_prev;
    logic [4:0]       fn;
    logic [2:0]       relay;
    logic [15:0]      ai_level;
    logic [2:0]       ai_target;
    logic             trip;
  } fmr_state_t;

  fmr_state_t st_ff;
  fmr_state_t nxt_st;

  fmr_sync_if din_if ();
  assign din_if.raw = din_pin;

  // Pins come from the field, so they cross into our clock first
  fmr_in_sync u_din_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clk_en  (clk_en),
    .pins    (din_if.sync)
  );

  // ==========================================================================
  // Helpers

  // Listed input function codes; anything else counts as unassigned
  function automatic logic [4:0] din_decode(input logic [15:0] code);
    logic [4:0] f;
    f = 5'h00;
    unique case (code)
      FMR_FN_START_STOP:    f[0] = 1'b1;
      FMR_FN_RAMP_FREEZE:   f[1] = 1'b1;
      FMR_FN_FAULT_RESET:   f[2] = 1'b1;
      FMR_FN_ENERGY_SAVING: f[3] = 1'b1;
      FMR_FN_EXT_TRIP:      f[4] = 1'b1;
      default:              f    = 5'h00;
    endcase
    return f;
  endfunction : din_decode

  // Status selected for one relay; unlisted codes keep it open
  function automatic logic relay_pick(input logic [15:0] code, input logic [6:0] s);
    logic r;
    r = 1'b0;
    unique case (code)
      FMR_ST_READY:      r = s[0];
      FMR_ST_ENABLED:    r = s[1];
      FMR_ST_ERROR:      r = s[2];
      FMR_ST_RUNNING:    r = s[3];
      FMR_ST_START_DONE: r = s[4];
      FMR_ST_CUR_LIMIT:  r = s[5];
      FMR_ST_ES_ACTIVE:  r = s[6];
      default:           r = 1'b0;
    endcase
    return r;
  endfunction : relay_pick

  // Codes a selector may legally hold
  function automatic logic sel_listed(input logic [15:0] code);
    return (code == FMR_FN_OFF) || (din_decode(code) != 5'h00) ||
           (relay_pick(code, 7'h7f)) || (code == FMR_FN_CUR_LIMIT) ||
           (code == FMR_FN_SHEAR_PIN) || (code == FMR_FN_OVERLOAD);
  endfunction : sel_listed

  // ==========================================================================
  // Combinational datapath
  logic [6:0]  status_vec;
  logic [2:0]  din_clean;
  logic [10:0] adc_clamped;
  logic [26:0] ai_product;
  logic        wr_ok;
  logic        user_prog;
  logic [2:0][15:0] din_eff;

  assign status_vec = {stat_energy_saving_active, stat_current_limit, stat_start_complete,
                       stat_running, stat_error, stat_enabled, stat_ready};
  assign din_clean  = din_if.clean;
  // Converter never exceeds full scale; clamp protects against a wild sample
  assign adc_clamped = (adc_code > FMR_ADC_FULL_SCALE) ? FMR_ADC_FULL_SCALE : adc_code;
  assign ai_product  = st_ff.ai_read * st_ff.ai_scale;
  assign wr_ok       = reg_wdata <= FMR_FN_END_OF_LIST;
  assign user_prog   = st_ff.ctrl[FMR_CTRL_USER_PROG_BIT];

  // Fixed assignments stand unless control is user-programmable
  always_comb begin
    din_eff[0] = user_prog ? st_ff.din_sel[0] : FMR_RST_DIN1_SEL;
    din_eff[1] = user_prog ? st_ff.din_sel[1] : FMR_RST_DIN2_SEL;
    din_eff[2] = user_prog ? st_ff.din_sel[2] : FMR_RST_DIN3_SEL;
  end

  // Next-state logic: register writes, reads, mapping and events
  always_comb begin
    nxt_st = st_ff;

    // Readings sampled every cycle
    nxt_st.ai_read    = adc_clamped;
    nxt_st.therm_read = (therm_code > FMR_THERM_OPEN) ? FMR_THERM_OPEN : therm_code;

    // Analogue target and proportional level
    unique case (st_ff.ai_sel)
      FMR_FN_CUR_LIMIT: nxt_st.ai_target = 3'b001;
      FMR_FN_SHEAR_PIN: nxt_st.ai_target = 3'b010;
      FMR_FN_OVERLOAD:  nxt_st.ai_target = 3'b100;
      default:          nxt_st.ai_target = 3'b000;
    endcase
    nxt_st.ai_level = ai_product[FMR_ADC_SHIFT +: 16];

    // Thermistor trip only when enabled by software
    nxt_st.trip = st_ff.ctrl[FMR_CTRL_THERM_EN_BIT] &&
                  (st_ff.therm_read > FMR_THERM_TRIP);

    // Mapped input functions
    nxt_st.fn = 5'h00;
    for (int i = 0; i < 3; i++) begin
      if (din_clean[i]) begin
        nxt_st.fn = nxt_st.fn | din_decode(din_eff[i]);
      end
    end
    nxt_st.din_prev = din_clean;

    // Relay drive
    for (int i = 0; i < 3; i++) begin
      nxt_st.relay[i] = relay_pick(st_ff.rly_sel[i], status_vec);
    end

    // Register writes; selectors above end of list are refused
    if (reg_wr) begin
      unique case (reg_addr)
        FMR_OFS_AI_SEL:      if (wr_ok) nxt_st.ai_sel = reg_wdata;
        FMR_OFS_AI_SCALE: begin
          nxt_st.ai_scale = (reg_wdata > FMR_SCALE_MAX) ? FMR_SCALE_MAX : reg_wdata;
        end
        FMR_OFS_DIN1_SEL:    if (wr_ok) nxt_st.din_sel[0] = reg_wdata;
        FMR_OFS_DIN2_SEL:    if (wr_ok) nxt_st.din_sel[1] = reg_wdata;
        FMR_OFS_DIN3_SEL:    if (wr_ok) nxt_st.din_sel[2] = reg_wdata;
        FMR_OFS_RLY_NC_SEL:  if (wr_ok) nxt_st.rly_sel[0] = reg_wdata;
        FMR_OFS_RLY_NO1_SEL: if (wr_ok) nxt_st.rly_sel[1] = reg_wdata;
        FMR_OFS_RLY_NO2_SEL: if (wr_ok) nxt_st.rly_sel[2] = reg_wdata;
        FMR_OFS_CTRL:        nxt_st.ctrl = reg_wdata[1:0];
        FMR_OFS_IRQ_MASK:    nxt_st.irq_mask = reg_wdata[2:0];
        default: ;
      endcase
    end

    // Read data, valid in the following cycle only
    nxt_st.rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        FMR_OFS_AI_SEL:      nxt_st.rdata = st_ff.ai_sel;
        FMR_OFS_AI_SCALE:    nxt_st.rdata = st_ff.ai_scale;
        FMR_OFS_AI_READ:     nxt_st.rdata = {5'h00, st_ff.ai_read};
        FMR_OFS_THERM_READ:  nxt_st.rdata = {5'h00, st_ff.therm_read};
        FMR_OFS_DIN1_SEL:    nxt_st.rdata = st_ff.din_sel[0];
        FMR_OFS_DIN2_SEL:    nxt_st.rdata = st_ff.din_sel[1];
        FMR_OFS_DIN3_SEL:    nxt_st.rdata = st_ff.din_sel[2];
        FMR_OFS_RLY_NC_SEL:  nxt_st.rdata = st_ff.rly_sel[0];
        FMR_OFS_RLY_NO1_SEL: nxt_st.rdata = st_ff.rly_sel[1];
        FMR_OFS_RLY_NO2_SEL: nxt_st.rdata = st_ff.rly_sel[2];
        FMR_OFS_CTRL:        nxt_st.rdata = {14'h0000, st_ff.ctrl};
        FMR_OFS_IRQ_STAT:    nxt_st.rdata = {13'h0000, st_ff.irq_stat};
        FMR_OFS_IRQ_MASK:    nxt_st.rdata = {13'h0000, st_ff.irq_mask};
        default:             nxt_st.rdata = 16'h0000;
      endcase
      // Reading the status clears it; fresh events below still land
      if (reg_addr == FMR_OFS_IRQ_STAT) begin
        nxt_st.irq_stat = 3'h0;
      end
    end

    // Sticky events: set wins over the read-clear of the same cycle
    if (nxt_st.trip && !st_ff.trip) begin
      nxt_st.irq_stat[FMR_IRQ_THERM_BIT] = 1'b1;
    end
    if (din_clean != st_ff.din_prev) begin
      nxt_st.irq_stat[FMR_IRQ_DIN_BIT] = 1'b1;
    end
    // A stored but unlisted selector is harmless, yet worth flagging
    if (reg_wr && wr_ok && !sel_listed(reg_wdata) &&
        (reg_addr == FMR_OFS_AI_SEL || reg_addr == FMR_OFS_DIN1_SEL ||
         reg_addr == FMR_OFS_DIN2_SEL || reg_addr == FMR_OFS_DIN3_SEL ||
         reg_addr == FMR_OFS_RLY_NC_SEL || reg_addr == FMR_OFS_RLY_NO1_SEL ||
         reg_addr == FMR_OFS_RLY_NO2_SEL)) begin
      nxt_st.irq_stat[FMR_IRQ_BADSEL_BIT] = 1'b1;
    end
  end

  // ==========================================================================
  // State register; defaults load on reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_ff            <= '0;
      st_ff.ai_sel     <= FMR_RST_AI_SEL;
      st_ff.ai_scale   <= FMR_RST_AI_SCALE;
      st_ff.din_sel[0] <= FMR_RST_DIN1_SEL;
      st_ff.din_sel[1] <= FMR_RST_DIN2_SEL;
      st_ff.din_sel[2] <= FMR_RST_DIN3_SEL;
      st_ff.rly_sel[0] <= FMR_RST_RLY_NC;
      st_ff.rly_sel[1] <= FMR_RST_RLY_NO1;
      st_ff.rly_sel[2] <= FMR_RST_RLY_NO2;
      st_ff.ctrl       <= FMR_RST_CTRL;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata              = st_ff.rdata;
  assign fn_start_stop          = st_ff.fn[0];
  assign fn_ramp_freeze         = st_ff.fn[1];
  assign fn_fault_reset         = st_ff.fn[2];
  assign fn_energy_saving_mode  = st_ff.fn[3];
  assign fn_external_trip_input = st_ff.fn[4];
  assign ai_level               = st_ff.ai_level;
  assign ai_target              = st_ff.ai_target;
  assign therm_trip             = st_ff.trip;
  assign relay_out              = st_ff.relay;
  // Level interrupt from unmasked sticky bits
  assign irq                    = |(st_ff.irq_stat & st_ff.irq_mask);

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  AST_AI_TARGET: assert property (
    clk_en && st_ff.ai_sel == FMR_FN_SHEAR_PIN |=> ai_target == 3'b010 || !$past(clk_en))
    else $error("analogue target not shear pin");

  AST_AI_FULLSCALE: assert property (
    clk_en && st_ff.ai_read == FMR_ADC_FULL_SCALE |=> ai_level == $past(st_ff.ai_scale))
    else $error("full scale input does not reach scaling level");

  AST_AI_READ_RANGE: assert property (
    st_ff.ai_read <= FMR_ADC_FULL_SCALE)
    else $error("analogue reading above full scale");

  AST_THERM_TRIP: assert property (
    clk_en && st_ff.ctrl[FMR_CTRL_THERM_EN_BIT] && st_ff.therm_read > FMR_THERM_TRIP
    |=> therm_trip)
    else $error("thermistor above threshold did not trip");

  AST_THERM_NOTRIP: assert property (
    clk_en && st_ff.therm_read <= FMR_THERM_TRIP |=> !therm_trip)
    else $error("thermistor tripped at or below threshold");

  AST_DIN_FIXED: assert property (
    clk_en && !user_prog && din_clean == 3'b010 |=> st_ff.fn == 5'h00)
    else $error("second input acted under fixed control");

  AST_DIN_MAP: assert property (
    clk_en && user_prog && din_clean == 3'b001 && st_ff.din_sel[0] == FMR_FN_EXT_TRIP
    |=> fn_external_trip_input && !fn_start_stop)
    else $error("first input not routed to external trip");

  AST_DEFAULTS: assert property (
    $fell(reset) |-> st_ff.din_sel[0] == FMR_RST_DIN1_SEL &&
    st_ff.din_sel[2] == FMR_RST_DIN3_SEL && st_ff.rly_sel[0] == FMR_RST_RLY_NC &&
    st_ff.rly_sel[2] == FMR_RST_RLY_NO2)
    else $error("defaults not loaded after reset");

  AST_RELAY: assert property (
    clk_en && st_ff.rly_sel[1] == FMR_ST_RUNNING |=> relay_out[1] == $past(stat_running))
    else $error("relay does not follow running status");

  AST_SEL_RANGE: assert property (
    clk_en && reg_wr && reg_addr == FMR_OFS_AI_SEL && reg_wdata > FMR_FN_END_OF_LIST
    |=> $stable(st_ff.ai_sel))
    else $error("selector accepted value past end of list");

  // Codes below the first or above the last status code select nothing
  AST_UNLISTED: assert property (
    clk_en && (st_ff.rly_sel[1] < FMR_ST_READY || st_ff.rly_sel[1] > FMR_ST_ES_ACTIVE)
    |=> !relay_out[1])
    else $error("unlisted relay code drove the relay");

endmodule : fmr_io_map

`default_nettype wire

// file: src/fmr_pkg.sv
// Package: register map, reset values and function codes of the I/O mapping bank
package fmr_pkg;

  // ==========================================================================
  // Register offsets (word addresses on the parameter port)
  localparam logic [15:0] FMR_OFS_AI_SEL     = 16'h25c0;
  localparam logic [15:0] FMR_OFS_AI_SCALE   = 16'h2600;
  localparam logic [15:0] FMR_OFS_AI_READ    = 16'h2640;
  localparam logic [15:0] FMR_OFS_THERM_READ = 16'h28c0;
  localparam logic [15:0] FMR_OFS_DIN1_SEL   = 16'h2ac0;
  localparam logic [15:0] FMR_OFS_DIN2_SEL   = 16'h2ac1;
  localparam logic [15:0] FMR_OFS_DIN3_SEL   = 16'h2ac2;
  localparam logic [15:0] FMR_OFS_RLY_NC_SEL = 16'h2d40;
  localparam logic [15:0] FMR_OFS_RLY_NO1_SEL = 16'h2d42;
  localparam logic [15:0] FMR_OFS_RLY_NO2_SEL = 16'h2d43;
  localparam logic [15:0] FMR_OFS_CTRL       = 16'h2e00;
  localparam logic [15:0] FMR_OFS_IRQ_STAT   = 16'h2e01;
  localparam logic [15:0] FMR_OFS_IRQ_MASK   = 16'h2e02;

  // ==========================================================================
  // Control register fields
  localparam int FMR_CTRL_USER_PROG_BIT = 0;
  localparam int FMR_CTRL_THERM_EN_BIT  = 1;
  // Interrupt status / mask fields
  localparam int FMR_IRQ_THERM_BIT = 0;
  localparam int FMR_IRQ_DIN_BIT   = 1;
  localparam int FMR_IRQ_BADSEL_BIT = 2;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] FMR_RST_AI_SEL   = 16'h0000;
  localparam logic [15:0] FMR_RST_AI_SCALE = 16'h0000;
  localparam logic [15:0] FMR_RST_DIN1_SEL = 16'h0118;
  localparam logic [15:0] FMR_RST_DIN2_SEL = 16'h0000;
  localparam logic [15:0] FMR_RST_DIN3_SEL = 16'h011f;
  localparam logic [15:0] FMR_RST_RLY_NC   = 16'h0247;
  localparam logic [15:0] FMR_RST_RLY_NO1  = 16'h024c;
  localparam logic [15:0] FMR_RST_RLY_NO2  = 16'h024e;
  localparam logic [1:0]  FMR_RST_CTRL     = 2'h0;

  // ==========================================================================
  // Function codes
  localparam logic [15:0] FMR_FN_OFF           = 16'h0000;
  localparam logic [15:0] FMR_FN_END_OF_LIST   = 16'h03e7;
  localparam logic [15:0] FMR_FN_CUR_LIMIT     = 16'h01a4;
  localparam logic [15:0] FMR_FN_SHEAR_PIN     = 16'h01af;
  localparam logic [15:0] FMR_FN_OVERLOAD      = 16'h01b9;
  localparam logic [15:0] FMR_FN_START_STOP    = 16'h0118;
  localparam logic [15:0] FMR_FN_RAMP_FREEZE   = 16'h011d;
  localparam logic [15:0] FMR_FN_FAULT_RESET   = 16'h011f;
  localparam logic [15:0] FMR_FN_ENERGY_SAVING = 16'h014a;
  localparam logic [15:0] FMR_FN_EXT_TRIP      = 16'h0127;
  localparam logic [15:0] FMR_ST_READY         = 16'h0245;
  localparam logic [15:0] FMR_ST_ENABLED       = 16'h0246;
  localparam logic [15:0] FMR_ST_ERROR         = 16'h0247;
  localparam logic [15:0] FMR_ST_RUNNING       = 16'h024c;
  localparam logic [15:0] FMR_ST_START_DONE    = 16'h024e;
  localparam logic [15:0] FMR_ST_CUR_LIMIT     = 16'h024f;
  localparam logic [15:0] FMR_ST_ES_ACTIVE     = 16'h0253;

  // ==========================================================================
  // Analogue and thermistor figures
  localparam logic [10:0] FMR_ADC_FULL_SCALE = 11'h400;
  localparam int          FMR_ADC_SHIFT      = 10;
  localparam logic [15:0] FMR_SCALE_MAX      = 16'h4000;
  localparam logic [10:0] FMR_THERM_TRIP     = 11'h190;
  localparam logic [10:0] FMR_THERM_OPEN     = 11'h400;

endpackage : fmr_pkg

// file: src/fmr_in_sync.sv
// Field-input synchroniser with agreement filter, and the interface that carries it
`timescale 1ns/10ps
`default_nettype none

// ============================================================================
// Raw pins in, filtered levels out
interface fmr_sync_if;
  logic [2:0] raw;
  logic [2:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface : fmr_sync_if

// ============================================================================
// Three stages; a new level is taken only when stages two and three agree
module fmr_in_sync (
  // Clock and control
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  // Pins
  fmr_sync_if.sync  pins
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] clean;
  } fmr_sync_state_t;

  fmr_sync_state_t st_ff;
  fmr_sync_state_t nxt_st;

  // Shift chain; first stage feeds only the second
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.s1    = pins.raw;
    nxt_st.s2    = st_ff.s1;
    nxt_st.s3    = st_ff.s2;
    for (int i = 0; i < 3; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.clean[i] = st_ff.s3[i];
      end
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign pins.clean = st_ff.clean;

endmodule : fmr_in_sync

`default_nettype wire

// file: testbench/fmr_field_model.sv
// Field-side model: input contacts, analogue source and motor thermistor loop
`timescale 1ns/10ps
`default_nettype none

// ============================================================================
// Wiring model
module fmr_field_model (
  // Clock
  input  wire logic        ref_clk,
  // Commands from the bench
  input  wire logic [2:0]  din_lvl,
  input  wire logic [11:0] adc_val,
  input  wire logic [11:0] therm_val,
  input  wire logic        therm_open,
  // Field side toward the block
  output var  logic [2:0]  din_pin,
  output var  logic [10:0] adc_code,
  output var  logic [10:0] therm_code
);
  initial begin
    din_pin    = 3'h0;
    adc_code   = 11'h000;
    therm_code = 11'h000;
  end

  // Converters saturate at full scale; a broken sensor loop reads as full scale
  always @(posedge ref_clk) begin
    din_pin    <= din_lvl;
    adc_code   <= (adc_val > 12'h400) ? 11'h400 : adc_val[10:0];
    therm_code <= (therm_open || therm_val > 12'h400) ? 11'h400 : therm_val[10:0];
  end
endmodule : fmr_field_model

`default_nettype wire

// file: testbench/fmr_tb.sv
// Self-checking bench of the I/O function mapping bank
`timescale 1ns/10ps
`default_nettype none

module tb
  import fmr_pkg::*;
;
  // ==========================================================================
  // Signals
  logic ref_clk, reset, clk_en, reg_wr, reg_rd, rd_take, look_go, therm_open, irq, therm_trip;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, ai_level, got;
  logic [11:0] adc_val, therm_val;
  logic [10:0] adc_code, therm_code;
  logic [6:0]  st;
  logic [4:0]  fnv;
  logic [2:0]  din_lvl, din_pin, ai_target, relay_out;
  logic [3:0]  look_sel;
  logic [19:0] q[$];
  logic [19:0] e;
  int n_errors, checked, a, s;
  logic [15:0] rst_adr[13] = '{FMR_OFS_AI_SEL, FMR_OFS_AI_SCALE, FMR_OFS_AI_READ,
    FMR_OFS_DIN1_SEL, FMR_OFS_DIN2_SEL, FMR_OFS_DIN3_SEL, FMR_OFS_RLY_NC_SEL,
    FMR_OFS_RLY_NO1_SEL, FMR_OFS_RLY_NO2_SEL, FMR_OFS_CTRL, FMR_OFS_IRQ_STAT,
    FMR_OFS_IRQ_MASK, 16'h2d41};
  logic [15:0] rst_val[13] = '{16'h0, 16'h0, 16'h0, 16'h0118, 16'h0, 16'h011f,
    16'h0247, 16'h024c, 16'h024e, 16'h0, 16'h0, 16'h0, 16'h0};
  logic [15:0] st_code[7] = '{16'd581, 16'd582, 16'd583, 16'd588, 16'd590, 16'd591, 16'd595};
  logic [15:0] din_code[5] = '{16'd280, 16'd285, 16'd287, 16'd330, 16'd295};
  logic [15:0] ai_code[3] = '{16'd420, 16'd431, 16'd441};

  logic fn_start_stop, fn_ramp_freeze, fn_fault_reset, fn_energy_saving_mode;
  logic fn_external_trip_input;
  assign fnv = {fn_external_trip_input, fn_energy_saving_mode, fn_fault_reset,
                fn_ramp_freeze, fn_start_stop};

  always #2 ref_clk = ~ref_clk;

  fmr_field_model FIELD (.ref_clk(ref_clk), .din_lvl(din_lvl), .adc_val(adc_val),
    .therm_val(therm_val), .therm_open(therm_open), .din_pin(din_pin),
    .adc_code(adc_code), .therm_code(therm_code));

  fmr_io_map DUT (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .adc_code(adc_code), .therm_code(therm_code), .din_pin(din_pin),
    .stat_ready(st[0]), .stat_enabled(st[1]), .stat_error(st[2]), .stat_running(st[3]),
    .stat_start_complete(st[4]), .stat_current_limit(st[5]),
    .stat_energy_saving_active(st[6]), .fn_start_stop(fn_start_stop),
    .fn_ramp_freeze(fn_ramp_freeze), .fn_fault_reset(fn_fault_reset),
    .fn_energy_saving_mode(fn_energy_saving_mode),
    .fn_external_trip_input(fn_external_trip_input), .ai_level(ai_level),
    .ai_target(ai_target), .therm_trip(therm_trip), .relay_out(relay_out), .irq(irq));

  // ==========================================================================
  // Bus and observation tasks
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic wr(input logic [15:0] ad, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= ad; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Expectation is queued before the strobe so the watcher always finds it
  task automatic rd(input logic [15:0] ad, input logic [15:0] x);
    q.push_back({4'h0, x});
    @(posedge ref_clk);
    reg_addr <= ad; reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic look(input logic [3:0] sl, input logic [15:0] x);
    q.push_back({sl, x});
    @(posedge ref_clk);
    look_sel <= sl; look_go <= 1'b1;
    @(posedge ref_clk);
    look_go <= 1'b0;
  endtask : look

  task automatic do_reset();
    @(posedge ref_clk);
    reset <= 1'b1;
    tick(12);
    reset <= 1'b0;
  endtask : do_reset

  task automatic report_and_stop();
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // ==========================================================================
  // Watcher: read data only stand one cycle, so sample mid-cycle after the take edge
  always @(posedge ref_clk) rd_take <= reg_rd;
  always @(negedge ref_clk) begin
    if (rd_take || look_go) begin
      e = q.pop_front();
      case (e[19:16])
        4'h1: got = {11'h0, fnv};
        4'h2: got = {13'h0, relay_out};
        4'h3: got = ai_level;
        4'h4: got = {13'h0, ai_target};
        4'h5: got = {15'h0, therm_trip};
        4'h6: got = {15'h0, irq};
        default: got = reg_rdata;
      endcase
      checked++;
      if (got !== e[15:0]) begin
        n_errors++;
        $display("[FAIL] t=%0t exp=%h got=%h", $time, e[15:0], got);
      end
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    report_and_stop();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    ref_clk = 0; reset = 1; clk_en = 1; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
    din_lvl = 0; adc_val = 0; therm_val = 0; therm_open = 0; st = 0; look_go = 0;
    look_sel = 0; rd_take = 0; n_errors = 0; checked = 0;
    void'($urandom(32'hc1165bdc));
    do_reset();
    for (int i = 0; i < 13; i++) rd(rst_adr[i], rst_val[i]);
    // Frozen strobes, range limit, read-only target
    clk_en <= 1'b0; wr(FMR_OFS_DIN2_SEL, 16'd285); clk_en <= 1'b1;
    rd(FMR_OFS_DIN2_SEL, 16'h0);
    wr(FMR_OFS_AI_SEL, 16'd999); rd(FMR_OFS_AI_SEL, 16'd999);
    wr(FMR_OFS_AI_SEL, 16'd1000); rd(FMR_OFS_AI_SEL, 16'd999);
    wr(FMR_OFS_AI_SCALE, 16'd16385); rd(FMR_OFS_AI_SCALE, 16'd16384);
    wr(FMR_OFS_AI_READ, 16'h0155); rd(FMR_OFS_AI_READ, 16'h0);
    do_reset();
    // First NO relay over every status code, status levels random
    st <= 7'($urandom);
    tick(4);
    look(4'h2, {13'h0, st[4], st[3], st[2]});
    for (int i = 0; i < 7; i++) begin
      wr(FMR_OFS_RLY_NO1_SEL, st_code[i]); tick(3);
      look(4'h2, {13'h0, st[4], st[i], st[2]});
    end
    wr(FMR_OFS_IRQ_MASK, 16'h4);
    wr(FMR_OFS_RLY_NO1_SEL, 16'd500); tick(3);
    look(4'h2, {13'h0, st[4], 1'b0, st[2]});
    look(4'h6, 16'h1); rd(FMR_OFS_IRQ_STAT, 16'h4);
    tick(2); look(4'h6, 16'h0); rd(FMR_OFS_IRQ_STAT, 16'h0);
    // Analogue routing and proportional scaling, first pass at full scale
    for (int i = 0; i < 3; i++) begin
      wr(FMR_OFS_AI_SEL, ai_code[i]); tick(3); look(4'h4, 16'(1 << i));
    end
    for (int i = 0; i < 5; i++) begin
      a = (i == 0) ? 1024 : $urandom_range(1024);
      s = $urandom_range(16384);
      adc_val <= 12'(a);
      wr(FMR_OFS_AI_SCALE, 16'(s)); tick(4);
      look(4'h3, 16'((a * s) >> 10));
      rd(FMR_OFS_AI_READ, 16'(a));
    end
    // Thermistor: trip only once enabled, strictly above the threshold
    therm_val <= 12'd401; tick(4); look(4'h5, 16'h0);
    wr(FMR_OFS_CTRL, 16'h2); tick(3); look(4'h5, 16'h1);
    therm_val <= 12'd400; tick(4); look(4'h5, 16'h0);
    therm_open <= 1'b1; tick(4); look(4'h5, 16'h1);
    rd(FMR_OFS_THERM_READ, 16'd1024);
    // Digital inputs: fixed map, then user-programmable over every code
    din_lvl <= 3'b001; tick(10); look(4'h1, 16'h1);
    wr(FMR_OFS_DIN1_SEL, 16'd285); tick(3); look(4'h1, 16'h1);
    wr(FMR_OFS_CTRL, 16'h3); tick(3); look(4'h1, 16'h2);
    for (int i = 0; i < 5; i++) begin
      wr(FMR_OFS_DIN1_SEL, din_code[i]); tick(3); look(4'h1, 16'(1 << i));
    end
    wr(FMR_OFS_DIN1_SEL, 16'd500); tick(3); look(4'h1, 16'h0);
    din_lvl <= 3'b000; tick(10);
    // Trip rise, input changes and the unlisted input code all left sticky bits
    rd(FMR_OFS_IRQ_STAT, 16'h7);
    for (int i = 0; i < 50 && q.size() != 0; i++) tick(1);
    if (q.size() != 0) n_errors++;
    report_and_stop();
  end
endmodule : tb

`default_nettype wire
